// >>> dv/sstx_exec_assertions.sv
// port checker for the execution block
`timescale 1ns/1ns
module sstx_chk (
	input wire clk,
	input wire resetn,
	input wire [15:0] instr,
	input wire wake_watchdog,
	input wire power_down_flag,
	input wire time_out_flag,
	input wire watchdog_clear,
	input wire osc_stop,
	input wire mem_rd,
	input wire mem_wr,
	input wire instr_taken
);
default clocking dc @(posedge clk);
endclocking
default disable iff (!resetn);
// -------------------------
// sequences and properties
// -------------------------
sequence s_rest;
	!instr_taken [*3];
endsequence
sequence s_enter;
	$rose(osc_stop);
endsequence
property p_cycle_len;
	instr_taken |=> s_rest;
endproperty
property p_sleep_pd;
	s_enter |-> ##[0:1] !power_down_flag;
endproperty
property p_sleep_to;
	s_enter |-> ##[0:1] time_out_flag;
endproperty
property p_sleep_wdt;
	watchdog_clear |-> ##[0:6] osc_stop;
endproperty
property p_sleep_op;
	s_enter |-> instr == 16'h0003;
endproperty
property p_wake_to;
	osc_stop && wake_watchdog |-> ##[1:12] !time_out_flag;
endproperty
property p_sub_dest;
	mem_wr |-> $past(instr[15:9]) == 7'h2b;
endproperty
property p_tst_nowr;
	$past(instr[15:9]) == 7'h33 |-> !mem_wr;
endproperty
property p_xor_nomem;
	instr[15:8] == 8'h0a |-> !mem_rd && !mem_wr;
endproperty
a_cycle_len: assert property (p_cycle_len)
	else $error("cycle shorter than four clocks");
a_sleep_pd: assert property (p_sleep_pd)
	else $error("power-down flag not cleared");
a_sleep_to: assert property (p_sleep_to)
	else $error("time-out flag not set");
a_sleep_wdt: assert property (p_sleep_wdt)
	else $error("watchdog cleared outside sleep");
a_sleep_op: assert property (p_sleep_op)
	else $error("sleep entered by wrong opcode");
a_wake_to: assert property (p_wake_to)
	else $error("watchdog wake kept time-out flag");
a_sub_dest: assert property (p_sub_dest)
	else $error("memory write without file destination");
a_tst_nowr: assert property (p_tst_nowr)
	else $error("test wrote memory");
a_xor_nomem: assert property (p_xor_nomem)
	else $error("literal xor touched memory");
endmodule
bind sstx_exec sstx_chk sstx_chk_i (.clk(clk), .resetn(resetn), .instr(instr),
	.wake_watchdog(wake_watchdog), .power_down_flag(power_down_flag),
	.time_out_flag(time_out_flag), .watchdog_clear(watchdog_clear), .osc_stop(osc_stop),
	.mem_rd(mem_rd), .mem_wr(mem_wr), .instr_taken(instr_taken));

// >>> dv/sstx_mem.sv
// data memory model on the far side of the execution block
`timescale 1ns/1ns
module sstx_mem (
	input wire clk,
	input wire [11:0] mem_addr,
	input wire mem_rd,
	input wire mem_wr,
	input wire [7:0] mem_wdata,
	output wire [7:0] mem_rdata
);
reg [7:0] m [0:4095];
reg [7:0] last = 8'h00;
reg hold = 1'b0;
// data shown during the strobe and one clock after, scrambled otherwise
assign mem_rdata = mem_rd ? m[mem_addr] : (hold ? last : ~last);
always @(posedge clk)
begin
	hold <= mem_rd;
	if (mem_rd)
		last <= m[mem_addr];
	if (mem_wr)
		m[mem_addr] <= mem_wdata;
end
endmodule

// >>> dv/test_sleep_subtract_test_xor_exec.sv
// self-checking testbench for the execution block
`timescale 1ns/1ns
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin fail_count++; \
	$display("ERROR %0t got %h want %h", $time, g, x); end end
module test_sleep_subtract_test_xor_exec;
reg clk = 0, resetn = 0, wake_watchdog = 0, wake_other = 0, started = 0;
reg [15:0] instr = 0, next_word = 0;
reg [3:0] bank_select_reg = 0;
reg tk = 0;
reg [7:0] w = 0, v, r, f;
reg [4:0] st = 0;
reg [8:0] s;
reg [11:0] a;
reg [1:0] da;
reg [12:0] e, q[$];
int fail_count = 0, n_compared = 0, disc = 0, wdc = 0, t, d0;
wire [7:0] w_reg, mem_rdata, mem_wdata;
wire [4:0] status;
wire [11:0] mem_addr;
wire power_down_flag, time_out_flag, watchdog_clear, osc_stop, mem_rd, mem_wr;
wire discard_fetch, instr_taken;
sstx_exec sstx_exec_i(.clk(clk), .resetn(resetn), .instr(instr), .next_word(next_word),
	.mem_rdata(mem_rdata), .bank_select_reg(bank_select_reg), .wake_watchdog(wake_watchdog),
	.wake_other(wake_other), .w_reg(w_reg), .status(status), .power_down_flag(power_down_flag),
	.time_out_flag(time_out_flag), .watchdog_clear(watchdog_clear), .osc_stop(osc_stop),
	.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
	.discard_fetch(discard_fetch), .instr_taken(instr_taken), .phase_out());
sstx_mem sstx_mem_i(.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
	.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
initial forever #20 clk = ~clk;
// monitor: pulse counts and result check at each cycle end
always @(posedge clk)
begin
	disc <= disc + discard_fetch;
	wdc <= wdc + watchdog_clear;
	tk <= (instr_taken === 1'b1);
	// results land on the write edge, one clock after the cycle-end flag rises
	if (tk && q.size() > 0)
	begin
		e = q.pop_front();
		`CHK({status, w_reg}, e)
	end
end
task complete_run;
	$display("compared %0d failed %0d", n_compared, fail_count);
	if (fail_count == 0 && n_compared > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
// bounded wait: 0 cycle end, 1 asleep, 2 awake
task wt(input int c);
	t = 0;
	do
	begin
		@(posedge clk);
		t++;
	end
	while ((c == 0 ? instr_taken : osc_stop ^ c[1]) !== 1'b1 && t < 60);
	if (t == 60)
	begin
		fail_count++;
		complete_run;
	end
endtask
// hand over the next word at a cycle end, note the expected result
task run(input [15:0] i, input bit p);
	if (started)
		wt(0);
	started = 1;
	instr <= i;
	#1;
	if (p)
		q.push_back({st, w});
endtask
initial
begin
	void'($urandom(79587));
	repeat (10) @(posedge clk);
	resetn <= 1;
	// literal xor, subtract with borrow, then a lone second word
	repeat (8)
	begin
		f = $urandom;
		w = w ^ f;
		st[4] = w[7];
		st[2] = w == 0;
		run({8'h0a, f}, 1);
		f = $urandom;
		v = $urandom;
		da = $urandom;
		a = $urandom;
		bank_select_reg <= a[11:8];
		a = da[0] ? {a[11:8], f} : {{4{f[7]}}, f};
		sstx_mem_i.m[a] = v;
		s = {1'b0, w} + {1'b0, ~v} + st[0];
		r = s[7:0];
		st = {r[7], (w[7] ^ v[7]) & (r[7] ^ w[7]), r == 0,
			({1'b0, w[3:0]} + {1'b0, ~v[3:0]} + st[0]) > 15, s[8]};
		if (!da[1])
			w = r;
		run({6'h15, da, f}, 1);
		run(16'hf000, 1);
		@(posedge clk);
		#1;
		`CHK(sstx_mem_i.m[a], da[1] ? r : v)
	end
	// test-skip-zero: nonzero, zero, zero before a two-word instruction
	for (int j = 0; j < 3; j++)
	begin
		sstx_mem_i.m[12'h010] = j ? 8'h00 : 8'h5c;
		next_word <= j[1] ? 16'hc000 : 16'h0000;
		d0 = disc;
		run(16'h6610, 1);
		repeat (3) run(16'hf000, 1);
		`CHK(disc - d0, j)
	end
	// sleep, woken by the watchdog and then by another source
	for (int j = 0; j < 2; j++)
	begin
		d0 = wdc;
		run(16'h0003, 0);
		wt(1);
		instr <= 16'hf000;
		repeat (2) @(posedge clk);
		`CHK(power_down_flag, 1'b0)
		`CHK(time_out_flag, 1'b1)
		`CHK(wdc - d0, 1)
		wake_watchdog <= !j;
		wake_other <= j;
		wt(2);
		wake_watchdog <= 0;
		wake_other <= 0;
		@(posedge clk);
		`CHK(time_out_flag, j[0])
	end
	complete_run;
end
endmodule

// >>> verilog/sstx_alu.v
// arithmetic for subtract with borrow and literal xor
`timescale 1ns/1ns
`include "sstx_regs.vh"
module sstx_alu (
	input wire [7:0] w_val,
	input wire [7:0] operand,
	input wire carry_in,
	input wire do_xor,
	output reg [7:0] result,
	output reg [4:0] flags_out,
	output reg [4:0] flags_mask
);
	reg [8:0] full;
	reg [4:0] low;
	// --------------------------------
	// result and flags
	// --------------------------------
	// borrow is the inverted carry; sum with inverted operand does the subtraction
	always @*
	begin
		full = 9'h000;
		low = 5'h00;
		flags_out = 5'h00;
		flags_mask = 5'h00;
		if (do_xor)
		begin
			result = w_val ^ operand;
			flags_mask = 5'h14;
		end
		else
		begin
			full = {1'b0, w_val} + {1'b0, ~operand} + {8'h00, carry_in};
			low = {1'b0, w_val[3:0]} + {1'b0, ~operand[3:0]} + {4'h0, carry_in};
			result = full[7:0];
			flags_mask = 5'h1f;
			flags_out[`SSTX_FLAG_C] = full[8];
			flags_out[`SSTX_FLAG_DC] = low[4];
			flags_out[`SSTX_FLAG_OV] = (w_val[7] != operand[7]) && (result[7] != w_val[7]);
		end
		flags_out[`SSTX_FLAG_Z] = (result == 8'h00);
		flags_out[`SSTX_FLAG_N] = result[7];
	end
endmodule

// >>> verilog/sstx_exec.v
// execution of sleep, subtract with borrow, test-skip-zero and literal xor
`timescale 1ns/1ns
`include "sstx_regs.vh"
module sstx_exec (
	input wire clk,
	input wire resetn,
	input wire [15:0] instr,
	input wire [15:0] next_word,
	input wire [7:0] mem_rdata,
	input wire [3:0] bank_select_reg,
	input wire wake_watchdog,
	input wire wake_other,
	output reg [7:0] w_reg,
	output reg [4:0] status,
	output reg power_down_flag,
	output reg time_out_flag,
	output reg watchdog_clear,
	output reg osc_stop,
	output reg [11:0] mem_addr,
	output reg mem_rd,
	output reg mem_wr,
	output reg [7:0] mem_wdata,
	output reg discard_fetch,
	output reg instr_taken,
	output reg [1:0] phase_out
);
	// ----------------------------------------
	// sequence states
	// ----------------------------------------
	localparam ST_RUN = 2'd0;
	localparam ST_NOP1 = 2'd1;
	localparam ST_NOP2 = 2'd2;
	localparam ST_SLEEP = 2'd3;

	reg [1:0] state;
	reg [1:0] next_state;
	reg [7:0] operand;
	reg skip_two;
	wire [1:0] phase;
	wire cycle_end;
	wire run;
	wire [7:0] alu_result;
	wire [4:0] alu_flags;
	wire [4:0] alu_mask;
	wire is_sleep;
	wire is_sub;
	wire is_tst;
	wire is_xor;
	wire is_second;
	wire [11:0] file_addr;
	wire next_two_word;
	reg [2:0] wake_sync;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign is_sleep = (instr == `SSTX_OP_SLEEP);
	assign is_sub = (instr[15:10] == `SSTX_OP_SUBFB);
	assign is_tst = (instr[15:9] == `SSTX_OP_TSTZ);
	assign is_xor = (instr[15:8] == `SSTX_OP_XORL);
	assign is_second = (instr[15:12] == `SSTX_OP_SECOND);
	assign next_two_word = (next_word[15:12] == 4'hc) || (next_word[15:12] == 4'he);
	// access bit low selects the access bank, high uses the bank select register
	assign file_addr = instr[8] ? {bank_select_reg, instr[7:0]}
		: (instr[7:0] < `SSTX_ACCESS_SPLIT ? {`SSTX_ACCESS_BANK, instr[7:0]}
		: {`SSTX_ACCESS_HIGH, instr[7:0]});
	assign run = (state != ST_SLEEP);

	sstx_phase u_phase (
		.clk(clk),
		.resetn(resetn),
		.run(run),
		.phase(phase),
		.cycle_end(cycle_end)
	);

	sstx_alu u_alu (
		.w_val(w_reg),
		.operand(is_xor ? instr[7:0] : operand),
		.carry_in(status[`SSTX_FLAG_C]),
		.do_xor(is_xor),
		.result(alu_result),
		.flags_out(alu_flags),
		.flags_mask(alu_mask)
	);

	// ----------------------------------------
	// wake inputs
	// ----------------------------------------
	// three-stage synchroniser on both wake sources
	reg [2:0] wake_o_sync;
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			wake_sync <= 3'b000;
			wake_o_sync <= 3'b000;
		end
		else
		begin
			wake_sync <= {wake_sync[1:0], wake_watchdog};
			wake_o_sync <= {wake_o_sync[1:0], wake_other};
		end
	end
	wire wdt_wake = wake_sync[1] & wake_sync[2];
	wire oth_wake = wake_o_sync[1] & wake_o_sync[2];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always @*
	begin
		next_state = state;
		case (state)
			ST_RUN:
			begin
				if (phase == 2'd3 && is_sleep)
					next_state = ST_SLEEP;
				else if (phase == 2'd3 && is_tst && operand == 8'h00)
					next_state = ST_NOP1;
			end
			ST_NOP1:
			begin
				if (phase == 2'd3)
					next_state = skip_two ? ST_NOP2 : ST_RUN;
			end
			ST_NOP2:
			begin
				if (phase == 2'd3)
					next_state = ST_RUN;
			end
			ST_SLEEP:
			begin
				if (wdt_wake || oth_wake)
					next_state = ST_RUN;
			end
			default:
				next_state = ST_RUN;
		endcase
	end

	// ----------------------------------------
	// execution by phase
	// ----------------------------------------
	// phase 0 decode, 1 read, 2 process, 3 write; nop cycles touch nothing but discard_fetch, raised in phase 3 of the first nop of a two-word skip
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			state <= ST_RUN;
			w_reg <= `SSTX_RST_W;
			status <= `SSTX_RST_STATUS;
			power_down_flag <= `SSTX_RST_PD;
			time_out_flag <= `SSTX_RST_TO;
			watchdog_clear <= 1'b0;
			osc_stop <= 1'b0;
			mem_addr <= 12'h000;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_wdata <= 8'h00;
			discard_fetch <= 1'b0;
			instr_taken <= 1'b0;
			phase_out <= 2'd0;
			operand <= 8'h00;
			skip_two <= 1'b0;
		end
		else
		begin
			state <= next_state;
			phase_out <= phase;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			watchdog_clear <= 1'b0;
			discard_fetch <= 1'b0;
			// raised during the write phase so fetch swaps the word before the next decode
			instr_taken <= (phase == 2'd2) && (state != ST_SLEEP);
			if (state == ST_RUN)
			begin
				case (phase)
					2'd0:
					begin
						// read address for file operands; sleep reads nothing
						if (is_sub || is_tst)
						begin
							mem_addr <= file_addr;
							mem_rd <= 1'b1;
						end
					end
					2'd1:
					begin
						if (is_sub || is_tst)
							operand <= mem_rdata;
					end
					2'd2:
					begin
						if (is_sleep)
						begin
							power_down_flag <= 1'b0;
							time_out_flag <= 1'b1;
							watchdog_clear <= 1'b1;
						end
					end
					2'd3:
					begin
						if (is_sleep)
							osc_stop <= 1'b1;
						if (is_sub && !instr[9])
							w_reg <= alu_result;
						if (is_sub && instr[9])
						begin
							mem_wr <= 1'b1;
							mem_wdata <= alu_result;
						end
						if (is_xor)
							w_reg <= alu_result;
						if (is_sub || is_xor)
							status <= (status & ~alu_mask) | (alu_flags & alu_mask);
						if (is_tst && operand == 8'h00)
						begin
							discard_fetch <= 1'b1;
							skip_two <= next_two_word;
						end
					end
					default:
					begin
					end
				endcase
			end
			else if (state == ST_SLEEP)
			begin
				if (wdt_wake)
				begin
					time_out_flag <= 1'b0;
					osc_stop <= 1'b0;
				end
				else if (oth_wake)
					osc_stop <= 1'b0;
			end
			else if (state == ST_NOP1 && phase == 2'd3 && skip_two)
				discard_fetch <= 1'b1;
		end
	end
endmodule

// >>> verilog/sstx_phase.v
// four-phase generator for the instruction cycle
`timescale 1ns/1ns
`include "sstx_regs.vh"
module sstx_phase (
	input wire clk,
	input wire resetn,
	input wire run,
	output reg [1:0] phase,
	output reg cycle_end
);
	// --------------------------------
	// phase counter
	// --------------------------------
	// counts decode, read, process, write; holds at decode while stopped
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			phase <= 2'd0;
			cycle_end <= 1'b0;
		end
		else if (!run)
		begin
			phase <= 2'd0;
			cycle_end <= 1'b0;
		end
		else
		begin
			phase <= phase + 2'd1;
			cycle_end <= (phase == (`SSTX_PHASES - 2'd1));
		end
	end
endmodule

// >>> verilog/sstx_regs.vh
// constants for the sleep, subtract, test and xor execution block
// Summary of operation
// - sleep clears the power-down flag to zero.
// - sleep sets the time-out flag to one.
// - sleep resets the watchdog counter and its postscaler to zero.
// - sleep is one word, one cycle; idle in phase two, sleeps in phase four.
// - a watchdog wake-up from sleep clears the time-out flag.
// - subtract with borrow computes w minus file minus inverted carry.
// - destination bit zero writes w, one writes the file register.
// - access bit zero picks the access bank, one picks the bank select register.
// - test-skip-zero discards the fetched next instruction when the file is zero.
// - skipping a two-word instruction makes the skip take three cycles.
// - literal xor puts w xor the 8-bit literal into w.
// - each instruction cycle has four phases: decode, read, process, write.
// - a second word, top nibble all ones, executes as a no-operation.
`ifndef SSTX_REGS_VH
`define SSTX_REGS_VH
`define SSTX_OP_SLEEP 16'h0003
`define SSTX_OP_SUBFB 6'h15
`define SSTX_OP_TSTZ 7'h33
`define SSTX_OP_XORL 8'h0a
`define SSTX_OP_SECOND 4'hf
`define SSTX_FLAG_C 0
`define SSTX_FLAG_DC 1
`define SSTX_FLAG_Z 2
`define SSTX_FLAG_OV 3
`define SSTX_FLAG_N 4
`define SSTX_RST_STATUS 5'h00
`define SSTX_RST_W 8'h00
`define SSTX_RST_BANK 4'h0
`define SSTX_RST_TO 1'b1
`define SSTX_RST_PD 1'b1
`define SSTX_ACCESS_BANK 4'h0
`define SSTX_ACCESS_SPLIT 8'h80
`define SSTX_ACCESS_HIGH 4'hf
`define SSTX_PHASES 2'd3
`endif
